// ===== hdl/icss_pkg.sv
// shared constants for the internal clock source and start-up block
package icss_pkg;
	// clock source select codes (fuse value 0 means programmed)
	localparam logic [3:0] SRC_RC_8M     = 4'h2;
	localparam logic [3:0] SRC_RC_LEGACY = 4'h3;
	localparam logic [3:0] SRC_LP_128K   = 4'h4;
	localparam logic [3:0] SRC_LF_XTAL   = 4'h6;
	// start-up fuse codes
	localparam logic [1:0] STC_00 = 2'h0;
	localparam logic [1:0] STC_01 = 2'h1;
	localparam logic [1:0] STC_10 = 2'h2;
	localparam logic [1:0] STC_11 = 2'h3;
	// factory (shipped) fuse state
	localparam logic [3:0] FACTORY_SRC   = SRC_RC_8M;
	localparam logic [1:0] FACTORY_STC   = STC_10;
	localparam logic       FACTORY_DIV8  = 1'b0;
	localparam logic       FUSE_PROGRAMMED = 1'b0;
	// delay counts, in source cycles or watchdog oscillator cycles
	localparam int         CNT_W         = 16;
	localparam logic [CNT_W-1:0] CK_NONE    = 16'h0000;
	localparam logic [CNT_W-1:0] CK_ONE     = 16'h0001;
	localparam logic [CNT_W-1:0] CK_PD      = 16'h0006;
	localparam logic [CNT_W-1:0] CK_RST     = 16'h000E;
	localparam logic [CNT_W-1:0] CK_1K      = 16'h0400;
	localparam logic [CNT_W-1:0] WDT_4MS    = 16'h0200;
	localparam int         TIME_4MS_MS   = 4;
	localparam int         TIME_64MS_MS  = 64;
	localparam int         WDT_64MS_DEF  = 8192;
	localparam int         CK_32K_DEF    = 32768;
	// legacy mode system clock divider and pll factors
	localparam logic [1:0] LEGACY_DIV_LAST = 2'h3;
	localparam logic [3:0] PLL_MULT_LEGACY = 4'h4;
	localparam logic [3:0] PLL_MULT_NORMAL = 4'h8;
	localparam logic [7:0] TRIM_RESET      = 8'h00;
	// start-up sequencer states
	typedef enum logic [1:0] {
		ST_RESET = 2'b00,
		ST_WAIT  = 2'b01,
		ST_RUN   = 2'b10,
		ST_SLEEP = 2'b11
	} icss_state_t;
endpackage

// ===== hdl/icss_delay_count.sv
// loadable down counter that steps on an enable tick
`timescale 1ns/1ps
module icss_delay_count
(
	// clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      rst_n,
	// load and step
	input  wire logic                      load,
	input  wire logic [icss_pkg::CNT_W-1:0] load_val,
	input  wire logic                      tick,
	// status
	output logic                           done
);
	import icss_pkg::*;

	logic [CNT_W-1:0] count;

	// load wins over a step so a fresh delay never loses its first count
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			count <= CK_NONE;
		else if (load)
			count <= load_val;
		else if (tick && count != CK_NONE)
			count <= count - CK_ONE;
	end

	assign done = (count == CK_NONE);
endmodule // icss_delay_count

// ===== hdl/icss_clock_startup.sv
// internal clock source selection, trim load and start-up hold
`timescale 1ns/1ps
module icss_clock_startup
#(
	parameter int WDT_64MS_CYCLES = icss_pkg::WDT_64MS_DEF,
	parameter int CK_32K_CYCLES   = icss_pkg::CK_32K_DEF
)
(
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       chip_reset,
	// fuses
	input  wire logic       fuses_blank,
	input  wire logic [3:0] clock_source_fuses,
	input  wire logic [1:0] startup_time_fuses,
	input  wire logic       initial_div_by8_fuse,
	input  wire logic       reset_pin_disable_fuse,
	input  wire logic [7:0] factory_trim,
	// software trim access
	input  wire logic       trim_wr,
	input  wire logic [7:0] trim_wdata,
	// sleep control
	input  wire logic       sleep_req,
	input  wire logic       wake_req,
	// oscillator ticks, one-cycle enables
	input  wire logic       rc_osc_tick,
	input  wire logic       lp_osc_tick,
	input  wire logic       lf_xtal_tick,
	input  wire logic       wdt_osc_tick,
	// oscillator control
	output logic [7:0]      osc_trim_value,
	output logic            rc_osc_enable,
	output logic            lp_osc_enable,
	output logic            lf_xtal_enable,
	output logic            rc_legacy_6m4,
	output logic            pll_enable,
	output logic [3:0]      pll_mult,
	// system clock and status
	output logic            sys_clk_en,
	output logic            prescale_div8,
	output logic            core_hold,
	output logic            config_reserved,
	output logic            wdt_clk_en
);
	import icss_pkg::*;

	localparam logic [CNT_W-1:0] WDT_64MS = CNT_W'(WDT_64MS_CYCLES);
	localparam logic [CNT_W-1:0] CK_32K   = CNT_W'(CK_32K_CYCLES);

	icss_state_t      state;
	icss_state_t      next_state;
	logic [3:0]       src;
	logic [1:0]       st_code;
	logic             div8;
	logic             legacy;
	logic             src_tick;
	logic [1:0]       div_cnt;
	logic [CNT_W-1:0] rst_ck;
	logic [CNT_W-1:0] rst_wdt;
	logic [CNT_W-1:0] pd_ck;
	logic             reserved;
	logic             load;
	logic [CNT_W-1:0] load_ck;
	logic [CNT_W-1:0] load_wdt;
	logic             ck_done;
	logic             wdt_done;

	// blank fuse array reads as the shipped configuration
	assign src    = fuses_blank ? FACTORY_SRC : clock_source_fuses;
	assign st_code = fuses_blank ? FACTORY_STC : startup_time_fuses;
	assign div8   = fuses_blank ? FACTORY_DIV8 : initial_div_by8_fuse;
	assign legacy = (src == SRC_RC_LEGACY);

	// source selection; unsupported codes keep the RC oscillator alive
	always_comb
	begin
		rc_osc_enable  = 1'b0;
		lp_osc_enable  = 1'b0;
		lf_xtal_enable = 1'b0;
		src_tick       = 1'b0;
		unique case (src)
			SRC_RC_8M, SRC_RC_LEGACY:
			begin
				rc_osc_enable = 1'b1;
				src_tick      = rc_osc_tick;
			end
			SRC_LP_128K:
			begin
				lp_osc_enable = 1'b1;
				src_tick      = lp_osc_tick;
			end
			SRC_LF_XTAL:
			begin
				lf_xtal_enable = 1'b1;
				src_tick       = lf_xtal_tick;
			end
			default:
			begin
				rc_osc_enable = 1'b1;
				src_tick      = rc_osc_tick;
			end
		endcase
	end

	// delay table; reserved codes fall back to the longest delay
	always_comb
	begin
		rst_ck   = CK_RST;
		rst_wdt  = WDT_64MS;
		pd_ck    = CK_PD;
		reserved = 1'b0;
		if (legacy)
		begin
			unique case (st_code)
				STC_00, STC_01: rst_wdt = WDT_64MS;
				STC_10:         rst_wdt = WDT_4MS;
				STC_11:
				begin
					pd_ck   = CK_ONE;
					rst_wdt = (reset_pin_disable_fuse == FUSE_PROGRAMMED) ?
						WDT_4MS : CK_NONE;
				end
			endcase
		end
		else if (src == SRC_LF_XTAL)
		begin
			rst_ck = CK_NONE;
			unique case (st_code)
				STC_00:
				begin
					pd_ck   = CK_1K;
					rst_wdt = WDT_4MS;
				end
				STC_01:
				begin
					pd_ck   = CK_1K;
					rst_wdt = WDT_64MS;
				end
				STC_10:
				begin
					pd_ck   = CK_32K;
					rst_wdt = WDT_64MS;
				end
				STC_11:
				begin
					pd_ck    = CK_32K;
					reserved = 1'b1;
				end
			endcase
		end
		else if (src == SRC_RC_8M || src == SRC_LP_128K)
		begin
			unique case (st_code)
				STC_00: rst_wdt = (reset_pin_disable_fuse == FUSE_PROGRAMMED) ?
					WDT_4MS : CK_NONE;
				STC_01: rst_wdt = WDT_4MS;
				STC_10: rst_wdt = WDT_64MS;
				STC_11: reserved = 1'b1;
			endcase
		end
		else
			reserved = 1'b1;
	end

	// sequencer: reset release and wake-up both enter the counted wait
	always_comb
	begin
		next_state = state;
		load       = 1'b0;
		load_ck    = pd_ck;
		load_wdt   = CK_NONE;
		unique case (state)
			ST_RESET:
				if (!chip_reset)
				begin
					next_state = ST_WAIT;
					load       = 1'b1;
					load_ck    = rst_ck;
					load_wdt   = rst_wdt;
				end
			ST_WAIT:
				if (ck_done && wdt_done)
					next_state = ST_RUN;
			ST_RUN:
				if (sleep_req)
					next_state = ST_SLEEP;
			ST_SLEEP:
				if (wake_req)
				begin
					next_state = ST_WAIT;
					load       = 1'b1;
				end
		endcase
		if (chip_reset)
			next_state = ST_RESET;
	end

	// sequencer state register
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			state <= ST_RESET;
		else
			state <= next_state;
	end

	// cycle part counts on the chosen source itself
	icss_delay_count u_ck_count
	(
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.load     (load),
		.load_val (load_ck),
		.tick     (src_tick),
		.done     (ck_done)
	);

	// real-time part counts on the watchdog oscillator
	icss_delay_count u_wdt_count
	(
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.load     (load),
		.load_val (load_wdt),
		.tick     (wdt_osc_tick),
		.done     (wdt_done)
	);

	// trim: factory value held in while reset lasts, software after
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			osc_trim_value <= TRIM_RESET;
		else if (chip_reset)
			osc_trim_value <= factory_trim;
		else if (trim_wr)
			osc_trim_value <= trim_wdata;
	end

	// legacy divide-by-four; free running so the ratio never slips
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			div_cnt <= 2'h0;
		else if (!legacy)
			div_cnt <= 2'h0;
		else if (src_tick)
			div_cnt <= div_cnt + 2'h1;
	end

	// system clock enable is gated off while the core is held
	always_comb
	begin
		core_hold  = (state != ST_RUN);
		sys_clk_en = !core_hold && src_tick &&
			(!legacy || div_cnt == LEGACY_DIV_LAST);
	end

	// outputs that follow the decoded fuses, plus the watchdog clock enable passed straight from wdt_osc_tick
	assign rc_legacy_6m4   = legacy;
	assign pll_enable      = legacy;
	assign pll_mult        = legacy ? PLL_MULT_LEGACY : PLL_MULT_NORMAL;
	assign prescale_div8   = (div8 == FUSE_PROGRAMMED);
	assign config_reserved = reserved;
	assign wdt_clk_en      = wdt_osc_tick;
endmodule // icss_clock_startup

// ===== tb/icss_clock_startup_sva.sv
// assertion checker for the clock start-up block
`timescale 1ns/1ps
module icss_sva
(
	// clock and reset
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic       chip_reset,
	// fuses and requests
	input wire logic       fuses_blank,
	input wire logic [3:0] clock_source_fuses,
	input wire logic [7:0] factory_trim,
	input wire logic       trim_wr,
	input wire logic [7:0] trim_wdata,
	input wire logic       wdt_osc_tick,
	// observed outputs
	input wire logic [7:0] osc_trim_value,
	input wire logic       rc_osc_enable,
	input wire logic       lp_osc_enable,
	input wire logic       lf_xtal_enable,
	input wire logic       rc_legacy_6m4,
	input wire logic       pll_enable,
	input wire logic [3:0] pll_mult,
	input wire logic       sys_clk_en,
	input wire logic       prescale_div8,
	input wire logic       core_hold,
	input wire logic       wdt_clk_en
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// effective source once blank fuses fall back to factory state
	logic [3:0] s;
	assign s = fuses_blank ? 4'h2 : clock_source_fuses;
	AST_TRIM_LOAD: assert property (chip_reset |=> osc_trim_value == $past(factory_trim))
		else $error("trim not loaded in reset");
	AST_TRIM_WR: assert property (trim_wr && !chip_reset |=> osc_trim_value == $past(trim_wdata))
		else $error("trim write lost");
	AST_RC: assert property (s == 4'h2 |-> rc_osc_enable && !pll_enable && pll_mult == 4'h8)
		else $error("rc source wrong");
	AST_LEGACY: assert property (s == 4'h3 |-> rc_legacy_6m4 && pll_enable && pll_mult == 4'h4)
		else $error("legacy mode wrong");
	AST_LP: assert property (s == 4'h4 |-> lp_osc_enable && !rc_legacy_6m4)
		else $error("low power source wrong");
	AST_LF: assert property (s == 4'h6 |-> lf_xtal_enable && !pll_enable)
		else $error("crystal source wrong");
	AST_WDT: assert property (wdt_clk_en == wdt_osc_tick)
		else $error("watchdog clock not passed");
	AST_BLANK: assert property (fuses_blank |-> prescale_div8 && rc_osc_enable)
		else $error("factory state wrong");
	AST_HOLD: assert property ($fell(chip_reset) |-> core_hold ##1 core_hold)
		else $error("core released early");
	AST_NOCLK: assert property (core_hold |-> !sys_clk_en)
		else $error("clock while held");
	cover property (s == 4'h3 && sys_clk_en);
	cover property ($fell(core_hold));
	cover property (trim_wr && !chip_reset);
endmodule // icss_sva
bind icss_clock_startup icss_sva icss_sva_inst (.*);

// ===== tb/icss_osc_model.sv
// behavioural on-chip oscillators giving one-cycle ticks
`timescale 1ns/1ps
module icss_osc_model
(
	// clock and enables
	input wire logic core_clk,
	input wire logic rc_osc_enable,
	input wire logic lp_osc_enable,
	input wire logic lf_xtal_enable,
	// ticks
	output logic     rc_osc_tick = 0,
	output logic     lp_osc_tick = 0,
	output logic     lf_xtal_tick = 0,
	output logic     wdt_osc_tick = 0
);
	int         sd = 37296;
	logic [3:0] r;
	// jittered rates, so counters must cope with gaps; a stopped source is silent
	always @(negedge core_clk)
	begin
		r = 4'($random(sd));
		rc_osc_tick <= rc_osc_enable & r[0];
		lp_osc_tick <= lp_osc_enable & (r[2:1] == 2'h0);
		lf_xtal_tick <= lf_xtal_enable & (r[2:1] == 2'h1);
		wdt_osc_tick <= r[3];
	end
endmodule // icss_osc_model

// ===== tb/tb.sv
// self-checking bench for the clock start-up block
`timescale 1ns/1ps
module tb;
	import icss_pkg::*;
	localparam int W64 = 16;
	localparam int K32 = 64;
	logic       core_clk = 0, rst_n = 0, chip_reset = 1, fuses_blank = 0;
	logic [3:0] clock_source_fuses = 4'h2, pll_mult;
	logic [1:0] startup_time_fuses = 2'h2;
	logic       initial_div_by8_fuse = 1, reset_pin_disable_fuse = 1;
	logic [7:0] factory_trim = 8'h00, trim_wdata = 8'h00, osc_trim_value;
	logic       trim_wr = 0, sleep_req = 0, wake_req = 0;
	logic       rc_osc_tick, lp_osc_tick, lf_xtal_tick, wdt_osc_tick;
	logic       rc_osc_enable, lp_osc_enable, lf_xtal_enable, rc_legacy_6m4, pll_enable;
	logic       sys_clk_en, prescale_div8, core_hold, config_reserved, wdt_clk_en;
	int         num_errors = 0, checked = 0, seed = 37296;
	always #5 core_clk = ~core_clk;
	icss_clock_startup #(.WDT_64MS_CYCLES(W64), .CK_32K_CYCLES(K32)) icss_clock_startup_inst (.*);
	icss_osc_model icss_osc_model_inst (.*);
	task automatic summarize();
		if (num_errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("[ERR] %0t got %0h exp %0h", $time, g, e);
		end
	endtask
	task automatic chk_rng(input int g, input int lo, input int hi);
		checked++;
		if (g < lo || g > hi)
		begin
			num_errors++;
			$display("[ERR] %0t got %0h exp %0h..%0h", $time, g, lo, hi);
		end
	endtask
	function automatic int tk(input logic [3:0] s);
		return s == 4'h4 ? lp_osc_tick : s == 4'h6 ? lf_xtal_tick : rc_osc_tick;
	endfunction
	// expected {source cycles, watchdog cycles} of a reset or wake delay
	function automatic logic [31:0] need(input logic [3:0] s, input logic [1:0] u,
		input logic p, input logic w);
		logic [15:0] ck, wd;
		ck = (s == 4'h6) ? 16'h0 : 16'hE;
		if (s == 4'h3)
			wd = (u == 2'h2) ? 512 : (u == 2'h3) ? (p ? 0 : 512) : W64;
		else if (s == 4'h6)
			wd = (u == 2'h0) ? 512 : W64;
		else if (s == 4'h2 || s == 4'h4)
			wd = (u == 2'h0) ? (p ? 0 : 512) : (u == 2'h1) ? 512 : W64;
		else
			wd = W64; // unsupported codes take the longest reset delay
		if (w)
		begin
			wd = 0;
			ck = (s == 4'h6) ? (u[1] ? 16'(K32) : 16'h400) : (s == 4'h3 && u == 2'h3) ? 1 : 6;
		end
		return {ck, wd};
	endfunction
	// hold must drop one or two edges after the later of both counts ends
	task automatic measure(input logic [3:0] s, input logic [31:0] n);
		int i, c, d, tc, td, m;
		c = 0;
		d = 0;
		tc = (n[31:16] == 0);
		td = (n[15:0] == 0);
		for (i = 1; i < 9000; i++)
		begin
			@(negedge core_clk);
			wake_req = 0;
			if (core_hold !== 1'b1)
				break;
			if (i > 1)
			begin
				c += tk(s);
				d += wdt_osc_tick;
			end
			if (tc == 0 && c == n[31:16])
				tc = i;
			if (td == 0 && d == n[15:0])
				td = i;
		end
		m = (tc > td) ? tc : td;
		chk_rng(i, m + 1, m + 2);
		if (i >= 9000)
			summarize();
	endtask
	initial
	begin
		int k, t, y;
		logic [3:0] es;
		logic [1:0] eu;
		logic [3:0] srcs [4];
		srcs = '{4'h2, 4'h3, 4'h4, 4'h6};
		repeat (20) @(negedge core_clk);
		rst_n = 1;
		// k 32 blank fuses, k 33 an unsupported source code that must fall back to rc
		for (k = 0; k < 34; k++)
		begin
			@(negedge core_clk);
			chip_reset = 1;
			fuses_blank = (k == 32);
			clock_source_fuses = fuses_blank ? 4'h6 : (k == 33) ? 4'h5 : srcs[k[4:3]];
			startup_time_fuses = k[2:1];
			reset_pin_disable_fuse = k[0];
			initial_div_by8_fuse = 1'($random(seed));
			factory_trim = 8'($random(seed));
			es = fuses_blank ? 4'h2 : clock_source_fuses;
			eu = fuses_blank ? 2'h2 : startup_time_fuses;
			trim_wdata = ~factory_trim;
			trim_wr = 1;
			@(negedge core_clk);
			trim_wr = 0;
			chk(osc_trim_value, factory_trim);
			chk(prescale_div8, {7'h0, fuses_blank | ~initial_div_by8_fuse});
			chk(config_reserved, (eu == 2'h3 && es != 4'h3) || es == 4'h5);
			chip_reset = 0;
			measure(es, need(es, eu, reset_pin_disable_fuse | fuses_blank, 0));
			trim_wdata = 8'($random(seed));
			trim_wr = 1;
			@(negedge core_clk);
			trim_wr = 0;
			chk(osc_trim_value, trim_wdata);
			t = 0;
			y = 0;
			repeat (200)
			begin
				@(negedge core_clk);
				t += tk(es);
				y += sys_clk_en;
			end
			if (es == 4'h3)
				chk_rng(y, t / 4, t / 4 + 1);
			else
				chk_rng(y, t, t);
			sleep_req = 1;
			@(negedge core_clk);
			sleep_req = 0;
			repeat (3) @(negedge core_clk);
			chk(core_hold, 1'b1);
			wake_req = 1;
			measure(es, need(es, eu, 1'b1, 1));
		end
		summarize();
	end
endmodule // tb
